// ===== rtl/serial_host_clock_address_ctl.sv
`timescale 1ns/1ps
// Operation
// [R01] address from five stored bits plus straps
// [R02] compare full address on each start
// [R03] reset address upper 1011, bit1 clear
// [R04] software edits clock control only while disabled
// [R05] bypass with zero divider is illegal
// [R06] reset clears clock control, phase set
// [R07] master idle clock level follows polarity
// [R08] phase and polarity only in spi
// [R09] phase zero slave: select toggles per word
// [R10] phase zero slave loads only when deselected
// [R11] phase one loads when shifter empty
// [R12] phase one slave: select may stay asserted
// [R13] phase zero master loads now, flags late
// [R14] bypass bit skips divide-by-eight prescaler
// [R15] slave ignores divider except i2c freeze
// [R16] divider ratio one to 256
// [R17] filter mode: bypass, reserved, narrow, wide
// [R18] narrow removes 50ns, wide 100ns spikes
// [R19] filters on clock and selected data input
// [R20] wait ten spike widths before enabling
// [R21] status read-only, reset by individual reset
// [R22] reserved clock control bits read zero
// [R23] enable clear resets port one cycle later
// [R24] i2c slave freeze holds clock low
// [R25] master clock from prescaler then divider
module serial_host_clock_address_ctl #(
  parameter int WORD_W = 24
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic sw_rst_i,
  input wire logic stop_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [23:0] reg_wdata_i,
  output logic [23:0] reg_rdata_o,
  input wire logic strap_addr_bit0_i,
  input wire logic strap_addr_bit2_i,
  input wire logic addr_valid_i,
  input wire logic [6:0] addr_rx_i,
  output logic addr_match_o,
  input wire logic rx_full_i,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n_o,
  input wire logic ss_n_i,
  input wire logic sda_i,
  input wire logic miso_i,
  input wire logic mosi_i,
  output logic sck_filt_o,
  output logic data_filt_o,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  input wire logic word_done_i,
  output logic shift_load_o,
  output logic [WORD_W-1:0] shift_word_o,
  input wire logic shift_ready_i,
  output logic busy_o
);

  logic [3:0] addr_upper_q;
  logic addr_bit1_q;
  logic [23:0] ckr_q;
  logic [6:0] ctrl_q;
  shc_pkg::clk_cfg_s cfg;
  logic en_q;
  logic port_rst;
  logic hard_rst;
  logic tde_q;
  logic [WORD_W-1:0] buf_q [2];
  logic [1:0] buf_cnt_q;
  logic buf_wp_q;
  logic buf_rp_q;
  logic shift_full_q;
  logic [WORD_W-1:0] shift_q;
  logic load_ok;
  logic load;
  logic busy_q;
  logic [2:0] pre_cnt_q;
  logic [7:0] div_cnt_q;
  logic tick;
  logic clk_run;
  logic sck_q;
  logic freeze_hold;
  logic [6:0] full_addr;
  logic sck_f_q;
  logic dat_f_q;
  logic [3:0] sck_cnt_q;
  logic [3:0] dat_cnt_q;
  logic data_raw;
  logic [3:0] filt_len;

  assign hard_rst = !rst_n_i || sw_rst_i;
  // bit 11 is reserved and has no place in the struct
  assign cfg = shc_pkg::clk_cfg_s'({ckr_q[13:12], ckr_q[10:0]});
  // individual reset follows the enable bit one cycle late
  assign port_rst = hard_rst || !en_q || stop_i; // see [R23]

  function automatic logic [3:0] filt_cycles(input logic [1:0] fm);
    case (fm)
      shc_pkg::FM_NARROW: filt_cycles = 4'(shc_pkg::NARROW_CYC); // see [R18]
      shc_pkg::FM_WIDE: filt_cycles = 4'(shc_pkg::WIDE_CYC); // see [R18]
      default: filt_cycles = 4'h0;
    endcase
  endfunction

  // slave address register
  always_ff @(posedge ref_clk_i) begin
    if (hard_rst) begin
      addr_upper_q <= shc_pkg::SAR_UPPER_RST; // see [R03]
      addr_bit1_q <= shc_pkg::SAR_BIT1_RST; // see [R03]
    end else if (reg_wr_i && reg_addr_i == shc_pkg::REG_SAR) begin
      addr_upper_q <= reg_wdata_i[shc_pkg::SAR_UPPER_LSB +: 4];
      addr_bit1_q <= reg_wdata_i[shc_pkg::SAR_BIT1_POS];
    end
  end

  assign full_addr = {addr_upper_q, strap_addr_bit2_i, addr_bit1_q,
                      strap_addr_bit0_i}; // see [R01]

  always_ff @(posedge ref_clk_i) begin
    if (port_rst) begin
      addr_match_o <= 1'b0;
    end else begin
      addr_match_o <= addr_valid_i && addr_rx_i == full_addr; // see [R02]
    end
  end

  // clock control: untouched by stop, only written while disabled
  always_ff @(posedge ref_clk_i) begin
    if (hard_rst) begin
      ckr_q <= shc_pkg::CKR_RST; // see [R06]
    end else if (reg_wr_i && reg_addr_i == shc_pkg::REG_CKR && !en_q) begin
      ckr_q <= reg_wdata_i & shc_pkg::CKR_MASK; // see [R04] [R22]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (hard_rst) begin
      ctrl_q <= 7'h00;
    end else if (reg_wr_i && reg_addr_i == shc_pkg::REG_CSR) begin
      ctrl_q <= reg_wdata_i[6:0]; // see [R21]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (hard_rst) begin
      en_q <= 1'b0;
    end else begin
      en_q <= ctrl_q[shc_pkg::CSR_EN_POS]; // see [R23]
    end
  end

  always_comb begin
    case (reg_addr_i)
      shc_pkg::REG_SAR: reg_rdata_o = {addr_upper_q, 1'b0, addr_bit1_q,
                                       18'h00000};
      shc_pkg::REG_CKR: reg_rdata_o = ckr_q; // see [R22]
      shc_pkg::REG_CSR: reg_rdata_o = {1'b0, busy_q, 4'h0, tde_q, 10'h000,
                                       ctrl_q};
      default: reg_rdata_o = 24'h000000;
    endcase
    if (!reg_rd_i) reg_rdata_o = 24'h000000;
  end

  // two-entry transmit holding buffer
  logic wr_ok;
  logic wr_fire;
  assign wr_ok = buf_cnt_q != 2'd2;
  assign wr_fire = reg_wr_i && reg_addr_i == shc_pkg::REG_TXH && wr_ok &&
                   !port_rst;

  always_comb begin
    if (!ctrl_q[shc_pkg::CSR_I2C_POS] && !cfg.pha) begin
      if (ctrl_q[shc_pkg::CSR_MST_POS]) load_ok = !shift_full_q; // see [R13]
      else load_ok = ss_n_i && !shift_full_q; // see [R10] [R09]
    end else begin
      load_ok = !shift_full_q; // see [R11] [R12]
    end
  end
  assign load = load_ok && buf_cnt_q != 2'd0 && shift_ready_i;

  always_ff @(posedge ref_clk_i) begin
    if (port_rst) begin
      buf_cnt_q <= 2'd0;
      buf_wp_q <= 1'b0;
      buf_rp_q <= 1'b0;
    end else begin
      if (wr_fire) buf_wp_q <= !buf_wp_q;
      if (load) buf_rp_q <= !buf_rp_q;
      buf_cnt_q <= buf_cnt_q + 2'(wr_fire) - 2'(load);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (wr_fire) buf_q[buf_wp_q] <= reg_wdata_i[WORD_W-1:0];
  end

  always_ff @(posedge ref_clk_i) begin
    if (port_rst) begin
      shift_full_q <= 1'b0;
      shift_q <= '0;
    end else if (load) begin
      shift_full_q <= 1'b1;
      shift_q <= buf_q[buf_rp_q];
    end else if (word_done_i) begin
      shift_full_q <= 1'b0;
    end
  end
  assign shift_load_o = load;
  assign shift_word_o = shift_q;

  // transmit-empty: set when a load empties the buffer, except phase-zero master sets at word end
  logic mst0;
  assign mst0 = !ctrl_q[shc_pkg::CSR_I2C_POS] && !cfg.pha &&
                ctrl_q[shc_pkg::CSR_MST_POS];
  always_ff @(posedge ref_clk_i) begin
    if (port_rst) begin
      tde_q <= 1'b1;
    end else if (mst0 ? (word_done_i && buf_cnt_q == 2'd0)
                      : (load && buf_cnt_q == 2'd1 && !wr_fire)) begin
      tde_q <= 1'b1; // see [R10] [R11] [R13]
    end else if (wr_fire) begin
      tde_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (port_rst) busy_q <= 1'b0;
    else busy_q <= shift_full_q || buf_cnt_q != 2'd0;
  end
  assign busy_o = busy_q;

  // clock generator
  assign clk_run = !port_rst && (ctrl_q[shc_pkg::CSR_MST_POS] ||
                   (ctrl_q[shc_pkg::CSR_I2C_POS] &&
                    ctrl_q[shc_pkg::CSR_FRZ_POS])); // see [R15]
  logic pre_tick;
  assign pre_tick = cfg.byp ||
                    pre_cnt_q == 3'(shc_pkg::PRESCALE_DIV - 1); // see [R14]
  assign tick = clk_run && pre_tick && div_cnt_q == cfg.div; // see [R16]

  always_ff @(posedge ref_clk_i) begin
    if (!clk_run) begin
      pre_cnt_q <= 3'h0;
      div_cnt_q <= 8'h00;
    end else begin
      pre_cnt_q <= cfg.byp ? 3'h0 : pre_cnt_q + 3'h1;
      if (pre_tick) div_cnt_q <= tick ? 8'h00 : div_cnt_q + 8'h01; // see [R25]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (port_rst) begin
      sck_q <= 1'b0;
    end else if (!ctrl_q[shc_pkg::CSR_I2C_POS] && !shift_full_q) begin
      sck_q <= cfg.pol; // see [R07] [R08]
    end else if (tick) begin
      sck_q <= !sck_q;
    end
  end

  assign freeze_hold = ctrl_q[shc_pkg::CSR_I2C_POS] &&
                       ctrl_q[shc_pkg::CSR_FRZ_POS] &&
                       !ctrl_q[shc_pkg::CSR_MST_POS] &&
                       (buf_cnt_q == 2'd0 || rx_full_i); // see [R24]
  assign sck_o = freeze_hold ? 1'b0 : sck_q;
  assign sck_oe_n_o = port_rst || !(ctrl_q[shc_pkg::CSR_MST_POS] ||
                                    freeze_hold);
  assign sdo_o = shift_q[WORD_W-1];
  assign sdo_oe_n_o = port_rst || !shift_full_q;

  // spike filters
  assign filt_len = filt_cycles(cfg.fm); // see [R17]
  always_comb begin
    if (ctrl_q[shc_pkg::CSR_I2C_POS]) data_raw = sda_i; // see [R19]
    else if (ctrl_q[shc_pkg::CSR_MST_POS]) data_raw = miso_i;
    else data_raw = mosi_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (port_rst) begin
      sck_f_q <= 1'b0;
      sck_cnt_q <= 4'h0;
    end else if (filt_len == 4'h0 || sck_i == sck_f_q) begin
      sck_f_q <= sck_i;
      sck_cnt_q <= 4'h0;
    end else if (sck_cnt_q == filt_len) begin
      sck_f_q <= sck_i; // see [R18]
      sck_cnt_q <= 4'h0;
    end else begin
      sck_cnt_q <= sck_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (port_rst) begin
      dat_f_q <= 1'b0;
      dat_cnt_q <= 4'h0;
    end else if (filt_len == 4'h0 || data_raw == dat_f_q) begin
      dat_f_q <= data_raw;
      dat_cnt_q <= 4'h0;
    end else if (dat_cnt_q == filt_len) begin
      dat_f_q <= data_raw; // see [R18]
      dat_cnt_q <= 4'h0;
    end else begin
      dat_cnt_q <= dat_cnt_q + 4'h1;
    end
  end
  assign sck_filt_o = sck_f_q;
  assign data_filt_o = dat_f_q;

  chk_addr_reset: assert property (@(posedge ref_clk_i) // see [R03]
    hard_rst |=> addr_upper_q == 4'hb && !addr_bit1_q)
    else $error("address not reset");
  chk_ckr_reset: assert property (@(posedge ref_clk_i) // see [R06]
    hard_rst |=> ckr_q == 24'h000001)
    else $error("clock control not reset");
  chk_ckr_locked: assert property (@(posedge ref_clk_i) // see [R04]
    disable iff (hard_rst) en_q |=> $stable(ckr_q))
    else $error("clock control changed while enabled");
  chk_match_addr: assert property (@(posedge ref_clk_i) // see [R02]
    disable iff (port_rst) addr_valid_i && addr_rx_i == full_addr
    |=> addr_match_o) else $error("address match missed");
  chk_idle_pol: assert property (@(posedge ref_clk_i) // see [R07]
    disable iff (port_rst) !ctrl_q[1] && !shift_full_q && !freeze_hold
    |=> sck_o == $past(cfg.pol)) else $error("idle clock level wrong");
  chk_ss_load: assert property (@(posedge ref_clk_i) // see [R10]
    disable iff (port_rst) !ctrl_q[1] && !cfg.pha && !ctrl_q[6] && load
    |-> ss_n_i) else $error("load while selected");
  chk_reserved_zero: assert property (@(posedge ref_clk_i) // see [R22]
    disable iff (hard_rst)
    (ckr_q & ~24'h0037ff) == 24'h000000) else $error("reserved bit set");
  chk_enable_delay: assert property (@(posedge ref_clk_i) // see [R23]
    disable iff (hard_rst) $fell(ctrl_q[0]) |=> !en_q)
    else $error("individual reset late");
  chk_freeze_low: assert property (@(posedge ref_clk_i) // see [R24]
    freeze_hold && !port_rst |-> !sck_o && !sck_oe_n_o)
    else $error("freeze not holding clock");

endmodule // serial_host_clock_address_ctl

// ===== rtl/shc_pkg.sv
package shc_pkg;

  // register indices on the core-side register port
  localparam logic [1:0] REG_SAR = 2'h0;
  localparam logic [1:0] REG_CKR = 2'h1;
  localparam logic [1:0] REG_CSR = 2'h2;
  localparam logic [1:0] REG_TXH = 2'h3;

  // slave address register fields
  localparam int SAR_UPPER_LSB = 20;
  localparam int SAR_BIT1_POS = 18;
  localparam logic [3:0] SAR_UPPER_RST = 4'hb;
  localparam logic SAR_BIT1_RST = 1'b0;

  // clock control fields
  localparam int CKR_PHASE_POS = 0;
  localparam int CKR_POL_POS = 1;
  localparam int CKR_BYP_POS = 2;
  localparam int CKR_DIV_LSB = 3;
  localparam int CKR_FM_LSB = 12;
  localparam logic [23:0] CKR_RST = 24'h000001;
  localparam logic [23:0] CKR_MASK = 24'h0037ff;

  // control/status fields
  localparam int CSR_EN_POS = 0;
  localparam int CSR_I2C_POS = 1;
  localparam int CSR_FRZ_POS = 4;
  localparam int CSR_MST_POS = 6;
  localparam int CSR_TDE_POS = 17;
  localparam int CSR_BUSY_POS = 22;
  localparam logic [23:0] CSR_CTRL_MASK = 24'h00007f;

  localparam int PRESCALE_DIV = 8;
  localparam int CLK_MHZ = 125;
  localparam int NARROW_NS = 50;
  localparam int WIDE_NS = 100;
  // longest removed spike, rounded up to whole cycles
  localparam int NARROW_CYC = (NARROW_NS * CLK_MHZ + 999) / 1000;
  localparam int WIDE_CYC = (WIDE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    FM_BYPASS = 2'b00,
    FM_RSVD = 2'b01,
    FM_NARROW = 2'b10,
    FM_WIDE = 2'b11
  } filt_mode_e;

  typedef struct packed {
    logic [1:0] fm;
    logic [7:0] div;
    logic byp;
    logic pol;
    logic pha;
  } clk_cfg_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE = 2'b10
  } shift_state_e;

endpackage

// ===== test/shc_far_end.sv
`timescale 1ns/1ps
// far-side spi master: selects the port and drives pulses on clock and data
module shc_far_end (
  input wire logic clk_i,
  input wire logic sel_i,
  input wire logic fire_i,
  input wire logic [7:0] width_i,
  output logic sck_o,
  output logic ss_n_o,
  output logic data_o
);
  logic [7:0] left_q = 8'h00;
  logic noise_q = 1'b0;
  always_ff @(posedge clk_i) begin
    if (fire_i) begin
      left_q <= width_i;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
    noise_q <= ~noise_q;
  end
  // select held across a whole word, dropped only between words
  assign ss_n_o = ~sel_i;
  // clock stands at the shared idle level outside pulses
  assign sck_o = (left_q != 8'h00);
  // data line released while deselected shows a changing pattern
  assign data_o = (left_q != 8'h00) | (ss_n_o & noise_q);
endmodule // shc_far_end

// ===== test/serial_host_clock_address_ctl_tb.sv
`timescale 1ns/1ps
module serial_host_clock_address_ctl_tb;
  logic ref_clk_i, rst_n_i, sw_rst_i, stop_i, reg_wr_i, reg_rd_i;
  logic [1:0] reg_addr_i;
  logic [23:0] reg_wdata_i, reg_rdata_o, shift_word_o, v, w, keep;
  logic strap_addr_bit0_i, strap_addr_bit2_i, addr_valid_i, addr_match_o;
  logic [6:0] addr_rx_i, a;
  logic sck_o, sck_oe_n_o, sck_filt_o, data_filt_o, shift_load_o;
  logic word_done_i, sel, fire, f_sck, f_ss_n, f_data, rxf;
  logic busy_o, sdo_o, sdo_oe_n_o;
  logic [7:0] width;
  int fails = 0;
  int n_tests = 0;
  int hits;
  serial_host_clock_address_ctl u_serial_host_clock_address_ctl (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sw_rst_i(sw_rst_i),
    .stop_i(stop_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .strap_addr_bit0_i(strap_addr_bit0_i),
    .strap_addr_bit2_i(strap_addr_bit2_i), .addr_valid_i(addr_valid_i),
    .addr_rx_i(addr_rx_i), .addr_match_o(addr_match_o), .rx_full_i(rxf),
    .sck_i(f_sck), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o), .ss_n_i(f_ss_n),
    .sda_i(f_data), .miso_i(f_data), .mosi_i(f_data),
    .sck_filt_o(sck_filt_o), .data_filt_o(data_filt_o), .sdo_o(sdo_o),
    .sdo_oe_n_o(sdo_oe_n_o), .word_done_i(word_done_i),
    .shift_load_o(shift_load_o), .shift_word_o(shift_word_o),
    .shift_ready_i(1'b1), .busy_o(busy_o)
  );
  shc_far_end u_shc_far_end (
    .clk_i(ref_clk_i), .sel_i(sel), .fire_i(fire), .width_i(width),
    .sck_o(f_sck), .ss_n_o(f_ss_n), .data_o(f_data)
  );
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  task automatic step;
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] ad, input logic [23:0] d);
    reg_wr_i = 1'b1;
    reg_addr_i = ad;
    reg_wdata_i = d;
    step;
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [1:0] ad, output logic [23:0] d);
    reg_rd_i = 1'b1;
    reg_addr_i = ad;
    #2;
    d = reg_rdata_o;
    step;
    reg_rd_i = 1'b0;
  endtask
  // disable first so the clock control write is accepted
  task automatic cfg(input logic [23:0] ckr, input logic [23:0] csr);
    wr(shc_pkg::REG_CSR, 24'h000000);
    step;
    wr(shc_pkg::REG_CKR, ckr);
    step;
    wr(shc_pkg::REG_CSR, csr);
    repeat (2) step;
  endtask
  task automatic watch(input int n);
    hits = 0;
    repeat (n) begin
      #2;
      if (shift_load_o === 1'b1) hits++;
      step;
    end
  endtask
  function automatic logic [6:0] exp_addr(logic [23:0] s, logic b2, logic b0);
    return {s[23:20], b2, s[18], b0};
  endfunction
  function automatic int exp_gap(input logic byp, input logic [7:0] dm);
    return (byp ? 1 : shc_pkg::PRESCALE_DIV) * (int'(dm) + 1);
  endfunction
  // cycles between two turns of the master clock, 0 if none seen
  task automatic edge_gap(output int g);
    int t0;
    logic s;
    t0 = -1;
    g = 0;
    s = sck_o;
    for (int i = 0; i < 600 && g == 0; i++) begin
      step;
      if (sck_o !== s) begin
        if (t0 >= 0) g = i - t0;
        t0 = i;
        s = sck_o;
      end
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #700us;
    fails++;
    $display("Error at %0t: run timed out", $time);
    print_verdict;
  end
  initial begin
    {sw_rst_i, stop_i, reg_wr_i, reg_rd_i, addr_valid_i} = 5'h00;
    {word_done_i, sel, fire, strap_addr_bit0_i, strap_addr_bit2_i} = 5'h00;
    reg_addr_i = 2'h0;
    reg_wdata_i = 24'h000000;
    addr_rx_i = 7'h00;
    width = 8'h00;
    rst_n_i = 1'b0;
    void'($urandom(32'hcd0d));
    rxf = 1'b0;
    repeat (10) step;
    rst_n_i = 1'b1;
    rd(shc_pkg::REG_SAR, v);
    chk(v, 24'hb00000);
    step;
    rd(shc_pkg::REG_CKR, v);
    chk(v, shc_pkg::CKR_RST);
    repeat (6) begin
      keep = 24'($urandom);
      keep[3] = 1'b1;
      wr(shc_pkg::REG_CKR, keep);
      rd(shc_pkg::REG_CKR, v);
      chk(v, keep & shc_pkg::CKR_MASK);
    end
    keep = keep & shc_pkg::CKR_MASK;
    wr(shc_pkg::REG_CSR, 24'h000001);
    repeat (2) step;
    wr(shc_pkg::REG_CKR, ~keep & 24'h0000f8);
    rd(shc_pkg::REG_CKR, v);
    chk(v, keep);
    stop_i = 1'b1;
    step;
    stop_i = 1'b0;
    rd(shc_pkg::REG_CKR, v);
    chk(v, keep);
    sw_rst_i = 1'b1;
    step;
    sw_rst_i = 1'b0;
    rd(shc_pkg::REG_SAR, v);
    chk(v, 24'hb00000);
    step;
    rd(shc_pkg::REG_CKR, v);
    chk(v, shc_pkg::CKR_RST);
    step;
    rd(shc_pkg::REG_CSR, v);
    chk(v & 24'h02007f, 24'h020000);
    wr(shc_pkg::REG_CSR, 24'h000003);
    repeat (8) begin
      v = 24'($urandom);
      v[23] = 1'b1;
      strap_addr_bit0_i = 1'($urandom);
      strap_addr_bit2_i = 1'($urandom);
      wr(shc_pkg::REG_SAR, v);
      a = exp_addr(v, strap_addr_bit2_i, strap_addr_bit0_i);
      for (int k = 0; k < 2; k++) begin
        addr_valid_i = 1'b1;
        addr_rx_i = a ^ 7'(k);
        step;
        addr_valid_i = 1'b0;
        chk({23'h0, addr_match_o}, {23'h0, k == 0});
        step;
      end
    end
    for (int p = 0; p < 2; p++) begin
      cfg(24'h000019 | 24'(p << 1), 24'h000041);
      repeat (5) step;
      chk({22'h0, sck_oe_n_o, sck_o}, 24'(p));
    end
    for (int m = 2; m < 4; m++) begin
      cfg(24'(m << 12) | 24'h000001, 24'h000000);
      sel = 1'b1;
      // wait over ten wide spike widths before the port is enabled
      repeat (140) step;
      wr(shc_pkg::REG_CSR, 24'h000001);
      repeat (2) step;
      width = 8'(((m == 2) ? shc_pkg::NARROW_NS : shc_pkg::WIDE_NS) *
                 shc_pkg::CLK_MHZ / 1000);
      fire = 1'b1;
      step;
      fire = 1'b0;
      repeat (16) begin
        chk({22'h0, sck_filt_o, data_filt_o}, 24'h0);
        step;
      end
      width = 8'h28;
      fire = 1'b1;
      step;
      fire = 1'b0;
      repeat (30) step;
      chk({22'h0, sck_filt_o, data_filt_o}, 24'h3);
      repeat (30) step;
    end
    cfg(24'h000000, 24'h000001);
    v = 24'($urandom);
    wr(shc_pkg::REG_TXH, v);
    watch(12);
    chk(24'(hits), 24'h0);
    rd(shc_pkg::REG_CSR, w);
    chk({23'h0, w[17]}, 24'h0);
    sel = 1'b0;
    watch(12);
    chk(24'(hits), 24'h1);
    chk(shift_word_o, v);
    rd(shc_pkg::REG_CSR, w);
    chk({23'h0, w[17]}, 24'h1);
    cfg(24'h000001, 24'h000001);
    sel = 1'b1;
    v = 24'($urandom);
    wr(shc_pkg::REG_TXH, v);
    watch(12);
    chk(24'(hits), 24'h1);
    chk(shift_word_o, v);
    sel = 1'b0;
    cfg(24'h000018, 24'h000041);
    v = 24'($urandom);
    wr(shc_pkg::REG_TXH, v);
    watch(4);
    chk(24'(hits), 24'h1);
    chk({21'h0, busy_o, sdo_oe_n_o, sdo_o}, {21'h0, 2'b10, v[23]});
    edge_gap(hits);
    chk(24'(hits), 24'(exp_gap(1'b0, 8'h03)));
    rd(shc_pkg::REG_CSR, w);
    chk({23'h0, w[17]}, 24'h0);
    word_done_i = 1'b1;
    step;
    word_done_i = 1'b0;
    step;
    rd(shc_pkg::REG_CSR, w);
    chk({23'h0, w[17]}, 24'h1);
    cfg(24'h00002c, 24'h000041);
    wr(shc_pkg::REG_TXH, v);
    edge_gap(hits);
    chk(24'(hits), 24'(exp_gap(1'b1, 8'h05)));
    cfg(24'h000001, 24'h000013);
    chk({22'h0, sck_oe_n_o, sck_o}, 24'h0);
    wr(shc_pkg::REG_TXH, v);
    step;
    wr(shc_pkg::REG_TXH, v);
    chk({23'h0, sck_oe_n_o}, 24'h1);
    rxf = 1'b1;
    step;
    chk({22'h0, sck_oe_n_o, sck_o}, 24'h0);
    print_verdict;
  end
endmodule // serial_host_clock_address_ctl_tb
